// [logic/macif_pkg.sv]
// constants of the multiplexed-address command interface
// assumes one 50 MHz clock and a classic wishbone register port
package macif_pkg;

    // ------------------------------------------------------------
    // pins, banks and command codes
    // ------------------------------------------------------------
    localparam int           ADDR_PINS  = 19;
    localparam int           ADDR_BITS  = 21;
    localparam int           BANK_BITS  = 3;
    localparam int           BANKS      = 8;
    localparam logic [1:0]   CMD_READ   = 2'h0;
    localparam logic [1:0]   CMD_WRITE  = 2'h1;
    localparam logic [1:0]   CMD_REF    = 2'h2;
    localparam logic [1:0]   CMD_MRS    = 2'h3;

    // ------------------------------------------------------------
    // mode register fields, positions in the joined address
    // ------------------------------------------------------------
    localparam int           MR_CFG_LSB = 0;
    localparam int           MR_CFG_W   = 3;
    localparam int           MR_BL_LSB  = 3;
    localparam int           MR_BL_W    = 2;
    localparam int           MR_MUX_BIT = 5;
    localparam int           MR_DLL_BIT = 7;
    localparam logic [2:0]   CFG_RST    = 3'h1;
    localparam logic [1:0]   BL_RST     = 2'h0;

    // ------------------------------------------------------------
    // configuration table in multiplexed mode, clocks
    // ------------------------------------------------------------
    localparam logic [3:0]   RC_TAB [3] = '{4'h4, 4'h6, 4'h8};
    localparam logic [3:0]   RL_TAB [3] = '{4'h5, 4'h7, 4'h9};
    localparam logic [3:0]   WL_TAB [3] = '{4'h6, 4'h8, 4'hA};
    localparam logic [3:0]   MUX_EXTRA  = 4'h1;
    localparam int           SR_W       = 16;

    // ------------------------------------------------------------
    // wishbone register map, byte addresses
    // ------------------------------------------------------------
    localparam int           WB_AW      = 8;
    localparam logic [7:0]   REG_CTRL   = 8'h00;
    localparam logic [7:0]   REG_STATUS = 8'h04;
    localparam logic [7:0]   REG_VIOL   = 8'h08;
    localparam int           CTRL_CHK   = 0;
    localparam int           ST_MUX     = 0;
    localparam int           ST_CFG     = 1;
    localparam int           ST_BL      = 4;
    localparam int           ST_DLL     = 6;
    localparam int           ST_RC      = 8;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_PHASE2 = 2'b10
    } macif_state_t;

endpackage

// [logic/macif_top.sv]
// command front end of an eight-bank dram with multiplexed addressing
// assumes command pins asynchronous to clk_i, registers on classic wishbone
`timescale 1ns/1ps
module macif_top (
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_i,
    input  wire logic                                 cs_n_i,
    input  wire logic                                 we_n_i,
    input  wire logic                                 ref_n_i,
    input  wire logic [macif_pkg::ADDR_PINS-1:0]      addr_i,
    input  wire logic [macif_pkg::BANK_BITS-1:0]      bank_sel_i,
    output logic                                      cmd_valid_o,
    output logic [1:0]                                cmd_kind_o,
    output logic [macif_pkg::BANK_BITS-1:0]           cmd_bank_o,
    output logic [macif_pkg::ADDR_BITS-1:0]           cmd_addr_o,
    output logic                                      rd_data_en_o,
    output logic                                      wr_data_en_o,
    output logic                                      mux_mode_o,
    output logic                                      dll_off_o,
    input  wire logic                                 wb_cyc_i,
    input  wire logic                                 wb_stb_i,
    input  wire logic                                 wb_we_i,
    input  wire logic [macif_pkg::WB_AW-1:0]          wb_adr_i,
    input  wire logic [3:0]                           wb_sel_i,
    input  wire logic [31:0]                          wb_dat_i,
    output logic [31:0]                               wb_dat_o,
    output logic                                      wb_ack_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] cfg_idx(input logic [2:0] cfg);
        cfg_idx = (cfg == 3'h2) ? 2'h1 : (cfg == 3'h3) ? 2'h2 : 2'h0;
    endfunction

    // joins both phases into one address word
    function automatic logic [macif_pkg::ADDR_BITS-1:0] mux_join(
        input logic [macif_pkg::ADDR_PINS-1:0] ax,
        input logic [macif_pkg::ADDR_PINS-1:0] ay);
        logic [macif_pkg::ADDR_BITS-1:0] a;
        a = '0;
        a[0] = ax[0]; a[3] = ax[3]; a[4] = ax[4]; a[5] = ax[5];
        a[8] = ax[8]; a[9] = ax[9]; a[10] = ax[10]; a[13] = ax[13];
        a[14] = ax[14]; a[17] = ax[17]; a[18] = ax[18];
        a[1] = ay[3]; a[2] = ay[4]; a[6] = ay[8]; a[7] = ay[9];
        a[11] = ay[13]; a[12] = ay[14]; a[16] = ay[17]; a[15] = ay[18];
        a[19] = ay[10]; a[20] = ay[0];
        mux_join = a;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int PW = macif_pkg::ADDR_PINS + macif_pkg::BANK_BITS + 3;
    logic [PW-1:0] pin_meta_r;
    logic [PW-1:0] pin_sync_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_r <= {PW{1'b1}};
            pin_sync_r <= {PW{1'b1}};
        end
        else
        begin
            pin_meta_r <= {cs_n_i, we_n_i, ref_n_i, bank_sel_i, addr_i};
            pin_sync_r <= pin_meta_r;
        end
    end

    logic                                 cs_s;
    logic [1:0]                           kind_s;
    logic [macif_pkg::BANK_BITS-1:0]      ba_s;
    logic [macif_pkg::ADDR_PINS-1:0]      ad_s;
    assign cs_s   = ~pin_sync_r[PW-1];
    assign kind_s = {~pin_sync_r[PW-3], ~pin_sync_r[PW-2]} ^ 2'h0;
    assign ba_s   = pin_sync_r[macif_pkg::ADDR_PINS +: macif_pkg::BANK_BITS];
    assign ad_s   = pin_sync_r[macif_pkg::ADDR_PINS-1:0];

    // ------------------------------------------------------------
    // mode state and phase sequencing
    // ------------------------------------------------------------
    macif_pkg::macif_state_t               st_r;
    logic                                  mux_r;
    logic [2:0]                            cfg_r;
    logic [1:0]                            bl_r;
    logic                                  dll_off_r;
    logic                                  chk_en_r;
    logic [1:0]                            hold_kind_r;
    logic [macif_pkg::BANK_BITS-1:0]       hold_ba_r;
    logic [macif_pkg::ADDR_PINS-1:0]       hold_ax_r;
    logic                                  ref_pend_r;
    logic [macif_pkg::BANK_BITS-1:0]       ref_ba_r;
    logic                                  new_cmd;
    logic                                  iss_v;
    logic [1:0]                            iss_kind;
    logic [macif_pkg::BANK_BITS-1:0]       iss_ba;
    logic [macif_pkg::ADDR_BITS-1:0]       iss_addr;
    logic [3:0]                            rc_now;
    logic [3:0]                            rl_base;
    logic [3:0]                            wl_base;

    assign new_cmd = cs_s && (st_r == macif_pkg::ST_IDLE);
    assign rc_now  = macif_pkg::RC_TAB[cfg_idx(cfg_r)];
    assign rl_base = macif_pkg::RL_TAB[cfg_idx(cfg_r)] - macif_pkg::MUX_EXTRA;
    assign wl_base = macif_pkg::WL_TAB[cfg_idx(cfg_r)] - macif_pkg::MUX_EXTRA;

    always_comb
    begin
        iss_v    = 1'b0;
        iss_kind = hold_kind_r;
        iss_ba   = hold_ba_r;
        iss_addr = mux_join(hold_ax_r, ad_s);
        if (st_r == macif_pkg::ST_PHASE2)
        begin
            iss_v = 1'b1;
        end
        else if (ref_pend_r)
        begin
            iss_v    = 1'b1;
            iss_kind = macif_pkg::CMD_REF;
            iss_ba   = ref_ba_r;
            // refresh carries only a bank; the held phase is from an older command
            iss_addr = '0;
        end
        else if (new_cmd && !mux_r)
        begin
            iss_v    = 1'b1;
            iss_kind = kind_s;
            iss_ba   = ba_s;
            iss_addr = {{(macif_pkg::ADDR_BITS-macif_pkg::ADDR_PINS){1'b0}}, ad_s};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r        <= macif_pkg::ST_IDLE;
            hold_kind_r <= macif_pkg::CMD_READ;
            hold_ba_r   <= '0;
            hold_ax_r   <= '0;
            ref_pend_r  <= 1'b0;
            ref_ba_r    <= '0;
        end
        else
        begin
            ref_pend_r <= 1'b0;
            unique case (st_r)
                macif_pkg::ST_IDLE:
                begin
                    if (new_cmd && mux_r && kind_s == macif_pkg::CMD_REF)
                    begin
                        ref_pend_r <= 1'b1;
                        ref_ba_r   <= ba_s;
                    end
                    else if (new_cmd && mux_r)
                    begin
                        st_r        <= macif_pkg::ST_PHASE2;
                        hold_kind_r <= kind_s;
                        hold_ba_r   <= ba_s;
                        hold_ax_r   <= ad_s;
                    end
                end
                macif_pkg::ST_PHASE2:
                begin
                    st_r <= macif_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // mode set: bank inputs and second-phase A8 (joined bit 6) never read
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mux_r     <= 1'b0;
            cfg_r     <= macif_pkg::CFG_RST;
            bl_r      <= macif_pkg::BL_RST;
            dll_off_r <= 1'b0;
        end
        else if (iss_v && iss_kind == macif_pkg::CMD_MRS && (!mux_r || iss_addr[macif_pkg::MR_MUX_BIT]))
        begin
            mux_r     <= iss_addr[macif_pkg::MR_MUX_BIT];
            cfg_r     <= iss_addr[macif_pkg::MR_CFG_LSB +: macif_pkg::MR_CFG_W];
            bl_r      <= iss_addr[macif_pkg::MR_BL_LSB +: macif_pkg::MR_BL_W];
            dll_off_r <= iss_addr[macif_pkg::MR_DLL_BIT];
        end
    end

    // ------------------------------------------------------------
    // data timing
    // ------------------------------------------------------------
    // commands in mux mode issue one clock after their first phase, so the
    // same distance from issue yields the extra latency clock
    logic [macif_pkg::SR_W-1:0] rd_sr_r;
    logic [macif_pkg::SR_W-1:0] wr_sr_r;
    logic [macif_pkg::SR_W-1:0] rd_ins;
    logic [macif_pkg::SR_W-1:0] wr_ins;
    assign rd_ins = (iss_v && iss_kind == macif_pkg::CMD_READ)
                  ? (macif_pkg::SR_W'(1) << (rl_base - 4'h1)) : '0;
    assign wr_ins = (iss_v && iss_kind == macif_pkg::CMD_WRITE)
                  ? (macif_pkg::SR_W'(1) << (wl_base - 4'h1)) : '0;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_sr_r <= '0;
            wr_sr_r <= '0;
        end
        else
        begin
            rd_sr_r <= (rd_sr_r >> 1) | rd_ins;
            wr_sr_r <= (wr_sr_r >> 1) | wr_ins;
        end
    end

    // ------------------------------------------------------------
    // row cycle tracking per bank
    // ------------------------------------------------------------
    // the device cannot refuse an early access; it only reports it
    logic [3:0]                 bank_cnt_r [macif_pkg::BANKS];
    logic [macif_pkg::BANKS-1:0] viol_r;
    logic [macif_pkg::BANKS-1:0] viol_clr;
    logic                       wb_wr;

    genvar gb;
    generate
        for (gb = 0; gb < macif_pkg::BANKS; gb++)
        begin : g_bank
            logic hit;
            assign hit = iss_v && iss_kind != macif_pkg::CMD_MRS
                       && iss_ba == macif_pkg::BANK_BITS'(gb);
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    bank_cnt_r[gb] <= 4'h0;
                    viol_r[gb]     <= 1'b0;
                end
                else
                begin
                    if (hit)
                        bank_cnt_r[gb] <= rc_now - 4'h1;
                    else if (bank_cnt_r[gb] != 4'h0)
                        bank_cnt_r[gb] <= bank_cnt_r[gb] - 4'h1;
                    if (hit && bank_cnt_r[gb] != 4'h0 && chk_en_r)
                        viol_r[gb] <= 1'b1;
                    else if (viol_clr[gb])
                        viol_r[gb] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // wishbone slave, one wait state, unmapped reads zero
    // ------------------------------------------------------------
    assign wb_wr    = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign viol_clr = (wb_wr && wb_adr_i == macif_pkg::REG_VIOL && wb_sel_i[0])
                    ? wb_dat_i[macif_pkg::BANKS-1:0] : '0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            chk_en_r <= 1'b1;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_wr && wb_adr_i == macif_pkg::REG_CTRL && wb_sel_i[0])
                chk_en_r <= wb_dat_i[macif_pkg::CTRL_CHK];
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i == macif_pkg::REG_CTRL)
                wb_dat_o[macif_pkg::CTRL_CHK] <= chk_en_r;
            else if (wb_adr_i == macif_pkg::REG_STATUS)
            begin
                wb_dat_o[macif_pkg::ST_MUX] <= mux_r;
                wb_dat_o[macif_pkg::ST_CFG +: 3] <= cfg_r;
                wb_dat_o[macif_pkg::ST_BL +: 2] <= bl_r;
                wb_dat_o[macif_pkg::ST_DLL] <= dll_off_r;
                wb_dat_o[macif_pkg::ST_RC +: 4] <= rc_now;
            end
            else if (wb_adr_i == macif_pkg::REG_VIOL)
                wb_dat_o[macif_pkg::BANKS-1:0] <= viol_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_valid_o <= 1'b0;
            cmd_kind_o  <= macif_pkg::CMD_READ;
            cmd_bank_o  <= '0;
            cmd_addr_o  <= '0;
        end
        else
        begin
            cmd_valid_o <= iss_v;
            cmd_kind_o  <= iss_kind;
            cmd_bank_o  <= iss_ba;
            cmd_addr_o  <= iss_addr;
        end
    end

    assign rd_data_en_o = rd_sr_r[0];
    assign wr_data_en_o = wr_sr_r[0];
    assign mux_mode_o   = mux_r;
    assign dll_off_o    = dll_off_r;

endmodule // macif_top

// [verif/macif_top_sva.sv]
// checker bound to macif_top: data latencies, mode flags, register answers
// assumes only the top's ports; config is shadowed from accepted mode sets
`timescale 1ns/1ps
module macif_top_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cmd_valid_o,
    input wire logic [1:0]  cmd_kind_o,
    input wire logic [20:0] cmd_addr_o,
    input wire logic        rd_data_en_o,
    input wire logic        wr_data_en_o,
    input wire logic        mux_mode_o,
    input wire logic        dll_off_o,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    // ------------------------------------------------------------
    // mode shadow and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic       mode_register_set_cmd;
    logic       rd;
    logic       wr;
    logic [1:0] cfg_r;
    logic       a5_r;
    logic       a7_r;
    assign mode_register_set_cmd = cmd_valid_o && cmd_kind_o == macif_pkg::CMD_MRS;
    assign rd  = cmd_valid_o && cmd_kind_o == macif_pkg::CMD_READ && mux_mode_o;
    assign wr  = cmd_valid_o && cmd_kind_o == macif_pkg::CMD_WRITE && mux_mode_o;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_r <= 2'h1;
            a5_r  <= 1'b0;
            a7_r  <= 1'b0;
        end
        // a mux-mode mode set with a5 low is dropped by the device, so skip it here too
        else if (mode_register_set_cmd && (cmd_addr_o[5] || !mux_mode_o))
        begin
            cfg_r <= (cmd_addr_o[2:0] == 3'h2) ? 2'h2 : (cmd_addr_o[2:0] == 3'h3) ? 2'h3 : 2'h1;
            a5_r  <= cmd_addr_o[5];
            a7_r  <= cmd_addr_o[7];
        end
    end
    // one window per config; only the term of the live config can fail
    a_read_latency:
        assert property (rd |-> ##3 (rd_data_en_o || cfg_r != 2'h1) ##2 (rd_data_en_o || cfg_r != 2'h2)
            ##2 (rd_data_en_o || cfg_r != 2'h3)) else $error("mux read data enable off time");
    a_write_latency:
        assert property (wr |-> ##4 (wr_data_en_o || cfg_r != 2'h1) ##2 (wr_data_en_o || cfg_r != 2'h2)
            ##2 (wr_data_en_o || cfg_r != 2'h3)) else $error("mux write data enable off time");
    a_mux_follows:
        assert property (mode_register_set_cmd |-> ##2 mux_mode_o == a5_r) else $error("mux flag differs from mode set");
    a_dll_follows:
        assert property (mode_register_set_cmd |-> ##2 dll_off_o == a7_r) else $error("loop off flag differs from mode set");
    a_flags_quiet:
        assert property ($changed(mux_mode_o) || $changed(dll_off_o) |-> mode_register_set_cmd || $past(mode_register_set_cmd) || $past(mode_register_set_cmd, 2))
            else $error("mode flag moved without a mode set");
    a_mux_mrs_a5:
        assert property (mode_register_set_cmd && $past(mux_mode_o) && !cmd_addr_o[5] |-> mux_mode_o && $stable(dll_off_o))
            else $error("mux mode set taken with a5 low");
    a_two_phase_gap:
        assert property (cmd_valid_o && mux_mode_o && cmd_kind_o != macif_pkg::CMD_REF |=> !cmd_valid_o)
            else $error("two-phase command followed at once");
    a_status_rc:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i == macif_pkg::REG_STATUS
            |-> wb_dat_o[11:8] == macif_pkg::RC_TAB[cfg_r - 2'h1] && wb_dat_o[0] == mux_mode_o)
            else $error("status row cycle or mux bit wrong");
    a_wb_answer:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
            else $error("bus ack not a single pulse one cycle after request");
    cover property (rd);
    cover property (cmd_valid_o && cmd_kind_o == macif_pkg::CMD_REF && mux_mode_o);
    cover property (mode_register_set_cmd && mux_mode_o);
endmodule // macif_top_sva

bind macif_top macif_top_sva u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_o(cmd_valid_o), .cmd_kind_o(cmd_kind_o),
    .cmd_addr_o(cmd_addr_o), .rd_data_en_o(rd_data_en_o), .wr_data_en_o(wr_data_en_o),
    .mux_mode_o(mux_mode_o), .dll_off_o(dll_off_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// [verif/macif_ctrl_model.sv]
// memory controller model driving the command pins of macif_top
// assumes the bench calls issue and nop from a single process
`timescale 1ns/1ps
module macif_ctrl_model #(
    parameter int MRSC_CLK = 6
) (
    input  wire logic        clk_i,
    output logic             cs_n_o,
    output logic             we_n_o,
    output logic             ref_n_o,
    output logic [18:0]      addr_o,
    output logic [2:0]       bank_o
);
    // ------------------------------------------------------------
    // mode flag, bank spacing, phase split
    // ------------------------------------------------------------
    logic mux_r = 1'b0;
    int   rc    = 4;
    int   cyc   = 0;
    int   last [8];
    initial
    begin
        cs_n_o  = 1'b1;
        we_n_o  = 1'b1;
        ref_n_o = 1'b1;
        addr_o  = 19'h0;
        bank_o  = 3'h0;
        foreach (last[i]) last[i] = -100;
    end
    always @(posedge clk_i) cyc <= cyc + 1;
    function automatic logic [18:0] ph2(input logic [20:0] a);
        ph2 = {a[15], a[16], ~a[16], ~a[15], a[12], a[11], ~a[12], ~a[11], a[19], a[7], a[6],
               ~a[7], ~a[6], ~a[5], a[2], a[1], ~a[2], ~a[1], a[20]};
    endfunction
    // idle address and bank pins keep toggling so a stale value is never mistaken for data
    task automatic nop(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            cs_n_o <= 1'b1;
            addr_o <= ~addr_o;
            bank_o <= ~bank_o;
        end
    endtask
    task automatic issue(input logic [1:0] k, input logic [2:0] b, input logic [20:0] a, input bit rude);
        while (!rude && k != macif_pkg::CMD_MRS && cyc - last[b] < rc + 2)
            nop(1);
        @(posedge clk_i);
        cs_n_o  <= 1'b0;
        we_n_o  <= ~k[0];
        ref_n_o <= ~k[1];
        bank_o  <= b;
        addr_o  <= mux_r ? a[18:0] ~^ 19'h66739 : a[18:0];
        last[b] = cyc;
        if (mux_r && k != macif_pkg::CMD_REF)
        begin
            @(posedge clk_i);
            cs_n_o <= 1'b1;
            bank_o <= ~b;
            addr_o <= ph2(a);
        end
        if (k == macif_pkg::CMD_MRS && (a[5] || !mux_r))
        begin
            rc = (a[2:0] == 3'h2) ? 6 : (a[2:0] == 3'h3) ? 8 : 4;
            if (a[5] && !mux_r)
            begin
                mux_r = 1'b1;
                nop(MRSC_CLK);
            end
        end
    endtask
endmodule // macif_ctrl_model

// [verif/test_mux_address_cmd_interface.sv]
// self-checking bench for macif_top with the controller model on its pins
// assumes macif_pkg compiled first and the checker bound to the top
`timescale 1ns/1ps
module test_mux_address_cmd_interface;
    // ------------------------------------------------------------
    // clock, design, model, monitors
    // ------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cs_n, we_n, ref_n, cmd_valid, rd_en, wr_en, mux_mode, dll_off, ack, d;
    logic [18:0] addr;
    logic [2:0]  bank, cbank;
    logic [1:0]  kind, bl;
    logic [20:0] caddr;
    logic [31:0] rdat, q;
    logic        cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    int          errors = 0, total_checks = 0, n_rd = 0, n_wr = 0, e_rd = 0, e_wr = 0;
    logic [25:0] exp_q[$], got_q[$];
    always #10 clk_i = ~clk_i;
    macif_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .we_n_i(we_n), .ref_n_i(ref_n),
        .addr_i(addr), .bank_sel_i(bank), .cmd_valid_o(cmd_valid), .cmd_kind_o(kind),
        .cmd_bank_o(cbank), .cmd_addr_o(caddr), .rd_data_en_o(rd_en), .wr_data_en_o(wr_en),
        .mux_mode_o(mux_mode), .dll_off_o(dll_off), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack)
    );
    macif_ctrl_model u_ctrl (
        .clk_i(clk_i), .cs_n_o(cs_n), .we_n_o(we_n), .ref_n_o(ref_n), .addr_o(addr), .bank_o(bank)
    );
    always @(posedge clk_i)
    begin
        if (cmd_valid === 1'b1) got_q.push_back({kind, cbank, caddr});
        if (rd_en === 1'b1) n_rd++;
        if (wr_en === 1'b1) n_wr++;
    end
    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        wwe  <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= dat;
        do @(posedge clk_i); while (ack !== 1'b1 && n++ < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) errors++;
    endtask
    function automatic logic [31:0] st_exp(input logic m, input int c, input logic [1:0] b, input logic o);
        st_exp = {20'h0, 4'(2 + 2 * c), 1'b0, o, b, 3'(c), m};
    endfunction
    task automatic cmd(input logic [1:0] k, input logic [2:0] b, input logic [20:0] a, input bit rude = 0);
        exp_q.push_back({k, k == macif_pkg::CMD_MRS ? 24'h0 : {b, !u_ctrl.mux_r ? {2'h0, a[18:0]}
                         : k == macif_pkg::CMD_REF ? 21'h0 : a}});
        if (k == macif_pkg::CMD_READ) e_rd++;
        if (k == macif_pkg::CMD_WRITE) e_wr++;
        u_ctrl.issue(k, b, a, rude);
    endtask
    task automatic drain();
        u_ctrl.nop(16);
        chk("command count", got_q.size(), exp_q.size());
        while (exp_q.size() > 0 && got_q.size() > 0)
        begin
            q = got_q.pop_front();
            if (q[25:24] == macif_pkg::CMD_MRS) q[23:0] = 24'h0;
            chk("command", q, exp_q.pop_front());
        end
        exp_q.delete();
        got_q.delete();
        chk("read enables", n_rd, e_rd);
        chk("write enables", n_wr, e_wr);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #400000;
        errors++;
        final_report();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hB9889BE7));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, macif_pkg::REG_STATUS, 32'h0);
        chk("status reset", q, 32'h0000_0402);
        wb(1'b0, macif_pkg::REG_CTRL, 32'h0);
        chk("ctrl reset", q, 32'h1);
        wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", q, 32'h0);
        repeat (3) cmd(macif_pkg::CMD_MRS, 3'h0, 21'h0);
        repeat (6) cmd(2'($urandom_range(0, 1)), 3'($urandom), 21'($urandom));
        cmd(macif_pkg::CMD_MRS, 3'h0, 21'h20);
        drain();
        for (int c = 1; c <= 3; c++)
        begin
            bl = 2'($urandom_range(0, 1));
            d = 1'($urandom);
            u_ctrl.nop(12);
            cmd(macif_pkg::CMD_MRS, 3'($urandom), {13'h0, d, 1'b1, 1'b1, bl, 3'(c)});
            for (int i = 0; i < 8; i++) cmd(i == 7 ? macif_pkg::CMD_READ : macif_pkg::CMD_REF, 3'(i), 21'($urandom));
            repeat (12) cmd(2'($urandom_range(0, 2)), 3'($urandom), 21'($urandom));
            drain();
            wb(1'b0, macif_pkg::REG_STATUS, 32'h0);
            chk("status config", q, st_exp(1'b1, c, bl, d));
            chk("loop off pin", dll_off, d);
            chk("mux pin", mux_mode, 1'b1);
            wb(1'b0, macif_pkg::REG_VIOL, 32'h0);
            chk("no early access", q, 32'h0);
        end
        cmd(macif_pkg::CMD_READ, 3'h5, 21'h0);
        cmd(macif_pkg::CMD_READ, 3'h5, 21'h1, 1);
        drain();
        wb(1'b0, macif_pkg::REG_VIOL, 32'h0);
        chk("early access flagged", q, 32'h20);
        wb(1'b1, macif_pkg::REG_VIOL, 32'h20);
        wb(1'b0, macif_pkg::REG_VIOL, 32'h0);
        chk("flag cleared", q, 32'h0);
        wb(1'b1, macif_pkg::REG_CTRL, 32'h0);
        cmd(macif_pkg::CMD_WRITE, 3'h2, 21'h0);
        cmd(macif_pkg::CMD_WRITE, 3'h2, 21'h2, 1);
        drain();
        wb(1'b0, macif_pkg::REG_VIOL, 32'h0);
        chk("check disabled", q, 32'h0);
        u_ctrl.nop(12);
        cmd(macif_pkg::CMD_MRS, 3'h0, 21'h2, 1);
        drain();
        wb(1'b0, macif_pkg::REG_STATUS, 32'h0);
        chk("a5 low ignored", q, st_exp(1'b1, 3, bl, d));
        final_report();
    end
endmodule // test_mux_address_cmd_interface
